// ---- rtl/wdh_pkg.sv ----
/*
 * package of the watchdog and halt controller: register map, field
 * positions, reset values, timing counts and the apb request carrier.
 * assumes a 10 MHz clock and a 32-bit apb with byte addresses.
 */
package wdh_pkg;

	// ----------------------------------------------------------------
	// register map (index times four gives the byte address)
	// ----------------------------------------------------------------
	localparam logic [7:0] SEL_IDX    = 8'h09;
	localparam logic [7:0] STATUS_IDX = 8'h0A;
	localparam logic [7:0] CMD_IDX    = 8'h0C;
	localparam logic [7:0] CFG_IDX    = 8'h0D;
	localparam logic [7:0] SEL_ADDR    = 8'(SEL_IDX * 4);
	localparam logic [7:0] STATUS_ADDR = 8'(STATUS_IDX * 4);
	localparam logic [7:0] CMD_ADDR    = 8'(CMD_IDX * 4);
	localparam logic [7:0] CFG_ADDR    = 8'(CFG_IDX * 4);

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int         PDF_BIT      = 4;
	localparam int         TO_BIT       = 5;
	localparam logic [7:0] SEL_RESET    = 8'h87;
	localparam int         CMD_CLR      = 0;
	localparam int         CMD_CLR1     = 1;
	localparam int         CMD_CLR2     = 2;
	localparam int         CMD_HALT     = 3;
	localparam int         CFG_EN       = 0;
	localparam int         CFG_RC       = 1;
	localparam int         CFG_DUAL     = 2;
	localparam int         CFG_FREQ     = 3;
	localparam int         CFG_MASK_LSB = 8;
	localparam logic [15:0] CFG_RESET   = 16'hFF0B;

	// ----------------------------------------------------------------
	// timing counts
	// ----------------------------------------------------------------
	localparam int          INSTR_DIV       = 4;
	localparam logic [1:0]  INSTR_LAST      = 2'(INSTR_DIV - 1);
	localparam logic [7:0]  BASE_LAST       = 8'hFF;
	localparam int          WAKE_DELAY_CYC  = 1024;
	localparam logic [10:0] WAKE_LAST       = 11'(WAKE_DELAY_CYC - 1);

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} wdh_apb_req_t;

endpackage

// ---- rtl/wdh_top.sv ----
/*
 * watchdog timer and halt sequencer with an apb register slave.
 * assumes rc_tick is a one-cycle pulse from the rc oscillator, and the
 * port a, interrupt and stack inputs are synchronous to clk.
 */
`timescale 1ns/1ns
module wdh_top (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire wdh_pkg::wdh_apb_req_t apb,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 rc_tick,
	input  wire logic [7:0]           port_a,
	input  wire logic                 irq_req,
	input  wire logic                 irq_enabled,
	input  wire logic                 stack_full,
	output logic                      timeout_pulse,
	output logic                      chip_reset,
	output logic                      warm_reset,
	output logic                      sys_osc_en,
	output logic                      io_hold,
	output logic                      resume_next,
	output logic                      take_irq,
	output logic                      sysclk_12mhz
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta;
	logic rst_sync;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  sel;
		logic        powerdown_flag;
		logic        to;
		logic [15:0] cfg;
		logic [1:0]  div4;
		logic [7:0]  div256;
		logic [6:0]  presc;
		logic        first_seen;
		logic        second_seen;
		logic        halted;
		logic [7:0]  pa_prev;
		logic        irq_block;
		logic        wake_pend;
		logic [10:0] wake_cnt;
		logic        wake_irq;
		logic        post_irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        timeout_pulse;
		logic        chip_reset;
		logic        warm_reset;
		logic        resume_next;
		logic        take_irq;
		logic        osc_on;
	} wdh_state_t;

	wdh_state_t s;
	wdh_state_t next_s;

	logic       acc;
	logic       wr;
	logic [3:0] cmd;
	logic       en;
	logic       inst_tick;
	logic       src_tick;
	logic [6:0] limit;
	logic       ovf;
	logic       clr_go;
	logic       halt_go;
	logic       pin_wake;
	logic       irq_wake;

	always_comb begin
		next_s = s;
		next_s.timeout_pulse = 1'b0;
		next_s.chip_reset    = 1'b0;
		next_s.warm_reset    = 1'b0;
		next_s.resume_next   = 1'b0;
		next_s.take_irq      = 1'b0;
		next_s.post_irq      = 1'b0;
		next_s.pa_prev       = port_a;

		// --------------------------------------------------------
		// apb slave, one wait state
		// --------------------------------------------------------
		acc = apb.psel && apb.penable && s.pready;
		wr  = acc && apb.pwrite;
		cmd = 4'h0;
		next_s.pready  = apb.psel && apb.penable && !s.pready;
		next_s.pslverr = 1'b0;
		next_s.prdata  = 32'h0000_0000;
		if (apb.psel && apb.penable && !s.pready) begin
			if (apb.paddr == wdh_pkg::SEL_ADDR) begin
				next_s.prdata = {24'h00_0000, s.sel};
			end else if (apb.paddr == wdh_pkg::STATUS_ADDR) begin
				next_s.prdata[wdh_pkg::PDF_BIT] = s.powerdown_flag;
				next_s.prdata[wdh_pkg::TO_BIT]  = s.to;
			end else if (apb.paddr == wdh_pkg::CFG_ADDR) begin
				next_s.prdata = {16'h0000, s.cfg};
			end else if (apb.paddr != wdh_pkg::CMD_ADDR) begin
				next_s.pslverr = 1'b1;
			end
		end
		if (wr) begin
			if (apb.paddr == wdh_pkg::SEL_ADDR) begin
				next_s.sel = apb.pwdata[7:0];
			end else if (apb.paddr == wdh_pkg::CMD_ADDR) begin
				cmd = apb.pwdata[3:0];
			end else if (apb.paddr == wdh_pkg::CFG_ADDR) begin
				next_s.cfg = apb.pwdata[15:0];
			end
		end

		// --------------------------------------------------------
		// watchdog counting
		// --------------------------------------------------------
		en        = s.cfg[wdh_pkg::CFG_EN];
		inst_tick = !s.halted && (s.div4 == wdh_pkg::INSTR_LAST);
		if (!s.halted) begin
			next_s.div4 = s.div4 + 2'd1;
		end
		src_tick = s.cfg[wdh_pkg::CFG_RC] ? rc_tick : inst_tick;
		limit    = 7'h7F >> (3'd7 - s.sel[2:0]);
		ovf      = en && src_tick && (s.div256 == wdh_pkg::BASE_LAST)
			&& (s.presc == limit);
		if (en && src_tick) begin
			next_s.div256 = s.div256 + 8'd1;
			if (s.div256 == wdh_pkg::BASE_LAST) begin
				next_s.presc = (s.presc == limit) ? 7'h00 : s.presc + 7'd1;
			end
		end

		// --------------------------------------------------------
		// clear instructions
		// --------------------------------------------------------
		clr_go = 1'b0;
		if (en && !s.halted) begin
			if (!s.cfg[wdh_pkg::CFG_DUAL]) begin
				clr_go = cmd[wdh_pkg::CMD_CLR];
			end else begin
				next_s.first_seen  = s.first_seen || cmd[wdh_pkg::CMD_CLR1];
				next_s.second_seen = s.second_seen || cmd[wdh_pkg::CMD_CLR2];
				if (next_s.first_seen && next_s.second_seen) begin
					clr_go             = 1'b1;
					next_s.first_seen  = 1'b0;
					next_s.second_seen = 1'b0;
				end
			end
		end
		halt_go = cmd[wdh_pkg::CMD_HALT] && !s.halted && !s.wake_pend;
		if (clr_go || (halt_go && en)) begin
			next_s.div256 = 8'h00;
			next_s.presc  = 7'h00;
		end
		if (clr_go) begin
			next_s.powerdown_flag = 1'b0;
			next_s.to  = 1'b0;
		end
		if (halt_go) begin
			next_s.halted    = 1'b1;
			next_s.powerdown_flag       = 1'b1;
			next_s.to        = 1'b0;
			next_s.irq_block = irq_req;
			next_s.div4      = 2'd0;
		end

		// --------------------------------------------------------
		// overflow and wake-up
		// --------------------------------------------------------
		pin_wake = |(s.pa_prev & ~port_a & s.cfg[wdh_pkg::CFG_MASK_LSB +: 8]);
		irq_wake = irq_req && !s.irq_block;
		if (!irq_req) begin
			next_s.irq_block = 1'b0;
		end
		if (ovf) begin
			next_s.timeout_pulse = 1'b1;
			next_s.to            = 1'b1;
			next_s.div256        = 8'h00;
			next_s.presc         = 7'h00;
			next_s.first_seen    = next_s.first_seen && !s.first_seen;
			next_s.second_seen   = next_s.second_seen && !s.second_seen;
			if (s.halted) begin
				next_s.warm_reset = 1'b1;
			end else begin
				next_s.chip_reset = 1'b1;
			end
		end
		if (s.halted && (ovf || pin_wake || irq_wake)) begin
			next_s.halted    = 1'b0;
			next_s.wake_pend = 1'b1;
			next_s.wake_cnt  = 11'd0;
			next_s.wake_irq  = irq_wake && !ovf && !pin_wake;
		end
		if (s.wake_pend) begin
			next_s.wake_cnt = s.wake_cnt + 11'd1;
			if (s.wake_cnt == wdh_pkg::WAKE_LAST) begin
				next_s.wake_pend = 1'b0;
				if (s.wake_irq && irq_enabled && !stack_full) begin
					next_s.post_irq = 1'b1;
				end else begin
					next_s.resume_next = 1'b1;
				end
			end
		end
		if (s.post_irq) begin
			next_s.take_irq = 1'b1;
		end
		next_s.osc_on = !next_s.halted;
	end

	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			s     <= '0;
			s.sel <= wdh_pkg::SEL_RESET;
			s.cfg <= wdh_pkg::CFG_RESET;
			s.osc_on <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata        = s.prdata;
	assign pready        = s.pready;
	assign pslverr       = s.pslverr;
	assign timeout_pulse = s.timeout_pulse;
	assign chip_reset    = s.chip_reset;
	assign warm_reset    = s.warm_reset;
	assign sys_osc_en    = s.osc_on;
	assign io_hold       = s.halted;
	assign resume_next   = s.resume_next;
	assign take_irq      = s.take_irq;
	assign sysclk_12mhz  = s.cfg[wdh_pkg::CFG_FREQ];

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync);

	property p_ovf_flag;
		ovf |=> s.to && s.timeout_pulse;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("timeout flag not set");

	property p_reset_kind;
		s.timeout_pulse |-> (s.chip_reset != s.warm_reset) && (s.warm_reset == $past(s.halted));
	endproperty
	a_reset_kind: assert property (p_reset_kind) else $error("wrong reset kind");

	property p_warm_wakes;
		(ovf && s.halted) |=> s.warm_reset && !s.halted && s.wake_pend;
	endproperty
	a_warm_wakes: assert property (p_warm_wakes) else $error("warm reset no wake");

	property p_halt_flags;
		(halt_go && !ovf) |=> s.powerdown_flag && !s.to && s.halted && (!en || s.div256 == 8'h00);
	endproperty
	a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");

	property p_clear;
		(clr_go && !halt_go && !ovf) |=> !s.powerdown_flag && s.div256 == 8'h00 && s.presc == 7'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");

	property p_disabled;
		!s.cfg[wdh_pkg::CFG_EN] |=> !s.timeout_pulse && !clr_go;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled watchdog acted");

	property p_halt_stop;
		(s.halted && !s.cfg[wdh_pkg::CFG_RC]) ##1 s.halted |-> $stable(s.div256);
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("counter ran in halt");

	property p_wake_delay;
		$rose(s.resume_next) || $rose(s.post_irq) |-> $past(s.wake_cnt) == wdh_pkg::WAKE_LAST;
	endproperty
	a_wake_delay: assert property (p_wake_delay) else $error("wake delay wrong");

	property p_irq_order;
		s.post_irq |=> s.take_irq && !s.resume_next;
	endproperty
	a_irq_order: assert property (p_irq_order) else $error("interrupt start wrong");

	property p_pready;
		s.pready |=> !s.pready;
	endproperty
	a_pready: assert property (p_pready) else $error("pready held");

	property p_osc_halt;
		s.halted != sys_osc_en;
	endproperty
	a_osc_halt: assert property (p_osc_halt) else $error("oscillator on in halt");

	property p_irq_block;
		(halt_go && irq_req) |=> s.irq_block;
	endproperty
	a_irq_block: assert property (p_irq_block) else $error("pending interrupt not blocked");

	property p_pin_wake;
		(s.halted && pin_wake) |=> !s.halted && s.wake_pend && !s.wake_irq;
	endproperty
	a_pin_wake: assert property (p_pin_wake) else $error("pin wake missed");

	property p_wake_start;
		$fell(s.halted) |-> s.wake_pend && s.wake_cnt == 11'd0;
	endproperty
	a_wake_start: assert property (p_wake_start) else $error("wake delay not started");

	property p_irq_take;
		s.post_irq |-> $past(s.wake_irq && irq_enabled && !stack_full);
	endproperty
	a_irq_take: assert property (p_irq_take) else $error("interrupt taken wrongly");

	property p_irq_blocked;
		(s.wake_pend && s.wake_cnt == wdh_pkg::WAKE_LAST && (!irq_enabled || stack_full))
			|=> s.resume_next && !s.post_irq;
	endproperty
	a_irq_blocked: assert property (p_irq_blocked) else $error("blocked wake not resumed");

	property p_count_step;
		(en && src_tick && s.div256 != wdh_pkg::BASE_LAST && !clr_go && !halt_go)
			|=> s.div256 == 8'($past(s.div256) + 8'd1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("base counter step wrong");

	// ----------------------------------------------------------------
	// cover
	// ----------------------------------------------------------------
	c_chip: cover property (s.chip_reset);
	c_warm: cover property (s.warm_reset);
	c_irq: cover property (s.take_irq);
	c_pin: cover property (s.halted && pin_wake);
	c_dual: cover property (clr_go && s.cfg[wdh_pkg::CFG_DUAL]);

endmodule

// ---- testbench/tb_watchdog_and_halt_control.sv ----
/*
 * self-checking bench of the watchdog and halt controller: registers over apb,
 * overflow when running and halted, clear, halt entry and the wake-up delay.
 * assumes the wdh_top module and wdh_pkg, a 10 MHz clock and no long-count parameters.
 */
`timescale 1ns/1ns
module tb_watchdog_and_halt_control;
	logic                  clk;
	logic                  resetn;
	wdh_pkg::wdh_apb_req_t req;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  rc_tick;
	logic [7:0]            port_a;
	logic                  irq_req;
	logic                  irq_enabled;
	logic                  stack_full;
	logic                  timeout_pulse;
	logic                  chip_reset;
	logic                  warm_reset;
	logic                  sys_osc_en;
	logic                  io_hold;
	logic                  resume_next;
	logic                  take_irq;
	logic                  sysclk_12mhz;
	int                    mismatches;
	int                    comparisons;
	logic [31:0]           rdat;
	logic                  rerr;
	int                    t;
	int                    c;
	int                    n;
	logic                  ch;
	logic                  wa;
	logic                  tk;

	wdh_top i_dut (.clk(clk), .resetn(resetn), .apb(req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rc_tick(rc_tick), .port_a(port_a), .irq_req(irq_req),
		.irq_enabled(irq_enabled), .stack_full(stack_full), .timeout_pulse(timeout_pulse),
		.chip_reset(chip_reset), .warm_reset(warm_reset), .sys_osc_en(sys_osc_en),
		.io_hold(io_hold), .resume_next(resume_next), .take_irq(take_irq),
		.sysclk_12mhz(sysclk_12mhz));

	// ----------------------------------------------------------------
	// checks and bus tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic int wdt_ticks(input int code);
		return 256 << code;
	endfunction

	task rchk(input int v, input int lo, input int hi);
		chk(32'((v >= lo) && (v <= hi)), 32'h1);
	endtask

	task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		repeat (50) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				rdat = prdata;
				rerr = pslverr;
				req <= '0;
				return;
			end
		end
		mismatches++;
		req <= '0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		ap(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask

	// rc ticks every other cycle until lim ticks or a timeout pulse
	task ticks(input int lim, output int k, output logic cr, output logic wr);
		k = 0;
		cr = 0;
		wr = 0;
		while (k < lim) begin
			@(posedge clk);
			if (rc_tick)
				k++;
			if (timeout_pulse === 1'b1) begin
				cr = chip_reset;
				wr = warm_reset;
				break;
			end
			rc_tick <= !rc_tick && (k < lim);
		end
	endtask

	task waitw(output int k, output logic ti);
		k = 0;
		ti = 0;
		repeat (1200) begin
			@(posedge clk);
			k++;
			if ((resume_next | take_irq) === 1'b1) begin
				ti = take_irq;
				return;
			end
		end
	endtask

	task finish_test;
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	initial begin
		#5_000_000;
		mismatches++;
		finish_test;
	end

	initial begin
		mismatches = 0;
		comparisons = 0;
		resetn = 0;
		req = '0;
		rc_tick = 0;
		port_a = 8'hFF;
		irq_req = 0;
		irq_enabled = 1;
		stack_full = 0;
		void'($urandom(70));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		chk({sysclk_12mhz, sys_osc_en, io_hold}, 32'h6);
		rd(wdh_pkg::SEL_ADDR, 32'h87);
		rd(wdh_pkg::STATUS_ADDR, 32'h0);
		rd(wdh_pkg::CFG_ADDR, 32'hFF0B);
		rd(8'h3C, 32'h0);
		chk(rerr, 1'b1);
		for (int i = 0; i < 3; i++) begin
			n = (i == 0) ? 0 : (i == 1) ? 7 : int'($urandom % 3);
			ap(1'b1, wdh_pkg::SEL_ADDR, 32'h80 | n);
			rd(wdh_pkg::SEL_ADDR, 32'h80 | n);
			if (n == 7)
				continue;
			ap(1'b1, wdh_pkg::CMD_ADDR, 32'h1);
			ticks(100, t, ch, wa);
			ap(1'b1, wdh_pkg::CMD_ADDR, 32'h1);
			ticks(5000, t, ch, wa);
			rchk(t, wdt_ticks(n), wdt_ticks(n) + 2);
			chk({ch, wa}, 2'b10);
			rd(wdh_pkg::STATUS_ADDR, 32'h20);
		end
		ap(1'b1, wdh_pkg::CMD_ADDR, 32'h8);
		@(posedge clk);
		chk({io_hold, sys_osc_en}, 2'b10);
		rd(wdh_pkg::STATUS_ADDR, 32'h10);
		ticks(5000, t, ch, wa);
		rchk(t, wdt_ticks(n), wdt_ticks(n) + 2);
		chk({ch, wa}, 2'b01);
		waitw(c, tk);
		rchk(c, 1020, 1030);
		rd(wdh_pkg::STATUS_ADDR, 32'h30);
		ap(1'b1, wdh_pkg::CMD_ADDR, 32'h1);
		rd(wdh_pkg::STATUS_ADDR, 32'h0);
		for (int k = 0; k < 3; k++) begin
			stack_full <= (k == 2);
			ap(1'b1, wdh_pkg::CMD_ADDR, 32'h8);
			repeat (5) @(posedge clk);
			if (k == 0)
				port_a <= 8'hFE;
			else
				irq_req <= 1'b1;
			waitw(c, tk);
			chk(tk, k == 1);
			rchk(c, 1020, 1030);
			chk(io_hold, 1'b0);
			port_a <= 8'hFF;
			irq_req <= 1'b0;
			ap(1'b1, wdh_pkg::CMD_ADDR, 32'h1);
		end
		ap(1'b1, wdh_pkg::SEL_ADDR, 32'h80);
		ap(1'b1, wdh_pkg::CFG_ADDR, 32'hFF09);
		ap(1'b1, wdh_pkg::CMD_ADDR, 32'h8);
		t = 0;
		repeat (1500) begin
			@(posedge clk);
			if (timeout_pulse === 1'b1)
				t++;
		end
		chk(t, 0);
		port_a <= 8'hF7;
		waitw(c, tk);
		rchk(c, 1020, 1030);
		ap(1'b1, wdh_pkg::CFG_ADDR, 32'hFF07);
		ap(1'b1, wdh_pkg::CMD_ADDR, 32'h6);
		ticks(100, t, ch, wa);
		ap(1'b1, wdh_pkg::CMD_ADDR, 32'h3);
		ticks(5000, t, ch, wa);
		rchk(t, wdt_ticks(0) - 100, wdt_ticks(0) - 98);
		chk(sysclk_12mhz, 1'b0);
		ap(1'b1, wdh_pkg::CMD_ADDR, 32'h2);
		ticks(100, t, ch, wa);
		ap(1'b1, wdh_pkg::CMD_ADDR, 32'h4);
		ticks(5000, t, ch, wa);
		rchk(t, wdt_ticks(0), wdt_ticks(0) + 2);
		ap(1'b1, wdh_pkg::CFG_ADDR, 32'hFF0A);
		ticks(600, t, ch, wa);
		chk(t, 600);
		finish_test;
	end
endmodule
